/* File: sim/fbm_flash_model.sv */
/* Behavioural flash device with sixteen words of array.
   Assumes the host strobes are registered on the same clock. */
`timescale 1ns/1ps
// ==========================================
// Flash model
module fbm_flash_model (
    input wire logic i_clock,
    input wire logic [20:0] i_addr,
    input wire logic [15:0] i_dq_out,
    input wire logic [15:0] i_dq_oe,
    input wire fbm_pkg::fbm_ctl_type i_ctl,
    output logic [15:0] o_dq_in,
    output logic o_ready_busy
);
    logic [15:0] mem [16];
    logic [15:0] word;
    logic [15:0] rd;
    logic [15:0] drv;
    localparam int RESET_READY_CYCLES = 80;
    logic tog = 1'b0;
    logic we_q = 1'b1;
    logic [3:0] wa_q = 4'h0;
    logic prot;
    int busy = 0;
    // Outermost words stand for the boot sectors, locked while protect_accel and program_high_voltage are both low.
    assign prot = !i_ctl.protect_accel && !i_ctl.program_high_voltage &&
        (i_addr[3:0] == 4'h0 || i_addr[3:0] == 4'hF);
    initial for (int i = 0; i < 16; i++)
        mem[i] = 16'hC030 | {4'h0, i[3:0], 4'h0, i[3:0]};
    always @(posedge i_clock) begin
        tog <= ~tog;
        we_q <= i_ctl.we_n;
        if (i_ctl.we_n && !we_q && !i_ctl.ce_n && i_ctl.reset_n) begin
            if (!prot) begin
                mem[i_addr[3:0]] <= i_dq_out;
            end
            wa_q <= i_addr[3:0];
            busy <= 20;
        end else if (!i_ctl.reset_n && busy > 0) begin
            // An interrupted program leaves its word spoiled.
            mem[wa_q] <= 16'h0000;
            busy <= RESET_READY_CYCLES;
        end else if (busy > 0)
            busy <= busy - 1;
    end
    assign o_ready_busy = (busy == 0);
    assign word = mem[i_addr[3:0]];
    assign rd = i_ctl.word_sel ? word :
        {8'h00, i_dq_out[15] ? word[15:8] : word[7:0]};
    assign drv = (i_ctl.ce_n || i_ctl.oe_n || !i_ctl.reset_n) ? 16'h0000 :
        (i_ctl.word_sel ? 16'hFFFF : 16'h00FF);
    assign o_dq_in = (i_dq_oe & i_dq_out) | (~i_dq_oe & drv & rd)
        | (~i_dq_oe & ~drv & {16{tog}});
endmodule // fbm_flash_model

/* File: sim/fbm_host_props.sv */
/* Pin-level checks for the flash host controller.
   Assumes it is bound to fbm_host and sees only its ports. */
`timescale 1ns/1ps
// ==========================================
// Checker
module fbm_host_props (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [fbm_pkg::DATA_W-1:0] o_dq_oe,
    input wire fbm_pkg::fbm_ctl_type o_ctl
);
    logic [7:0] low_q;
    logic [7:0] rec_q;
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            low_q <= 8'h00;
            rec_q <= 8'hFF;
        end else begin
            low_q <= o_ctl.reset_n ? 8'h00 : low_q + 8'h01;
            rec_q <= !o_ctl.reset_n ? 8'h00 :
                     (rec_q == 8'hFF ? rec_q : rec_q + 8'h01);
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    a_read_strobes: assert property (
        !o_ctl.oe_n |-> !o_ctl.ce_n && o_ctl.we_n) else $error("bad read");
    a_write_strobes: assert property (
        !o_ctl.we_n |-> !o_ctl.ce_n && o_ctl.oe_n) else $error("bad write");
    a_read_no_drive: assert property (
        !o_ctl.oe_n |-> o_dq_oe[14:0] == 15'h0000) else $error("bus fight");
    a_byte_float: assert property (
        !o_ctl.word_sel |-> o_dq_oe[14:8] == 7'h00) else $error("byte hi");
    a_byte_addr: assert property (
        !o_ctl.word_sel && !o_ctl.oe_n |-> o_dq_oe[15]) else $error("no a-1");
    a_write_pulse: assert property (
        $fell(o_ctl.we_n) |-> (!o_ctl.we_n)[*6] ##[1:4] o_ctl.we_n)
        else $error("write pulse length");
    a_read_hold: assert property (
        $fell(o_ctl.oe_n) |-> (!o_ctl.oe_n)[*8]) else $error("short read");
    a_reset_width: assert property (
        $rose(o_ctl.reset_n) |-> low_q >= fbm_pkg::RP_CYCLES)
        else $error("short reset pulse");
    a_reset_recover: assert property (
        $fell(o_ctl.oe_n) |-> rec_q >= fbm_pkg::RH_CYCLES)
        else $error("read too soon after reset");
endmodule // fbm_host_props

bind fbm_host fbm_host_props u_props (.i_clock(i_clock), .i_rstn(i_rstn),
    .o_dq_oe(o_dq_oe), .o_ctl(o_ctl));

/* File: sim/tb_fbm_host.sv */
/* Self-checking bench for the flash host controller.
   Assumes the flash model and the checker are compiled with it. */
`timescale 1ns/1ps
// ==========================================
// Bench
module tb_fbm_host;
    logic i_clock;
    logic i_rstn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [20:0] fa;
    logic [15:0] dqo;
    logic [15:0] dqe;
    logic [15:0] dqi;
    fbm_pkg::fbm_ctl_type ctl;
    logic rdy;
    logic [31:0] d;
    int failures = 0;
    int comparisons = 0;
    fbm_host DUT (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_flash_addr(fa), .o_dq_out(dqo), .o_dq_oe(dqe), .i_dq_in(dqi),
        .o_ctl(ctl), .i_ready_busy_out(rdy));
    fbm_flash_model u_flash (.i_clock(i_clock), .i_addr(fa), .i_dq_out(dqo),
        .i_dq_oe(dqe), .i_ctl(ctl), .o_dq_in(dqi), .o_ready_busy(rdy));
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic chk(input logic [31:0] e);
        comparisons++;
        if (d !== e) begin
            failures++;
            $display("mismatch %0t got %h exp %h", $time, d, e);
        end
    endtask
    task automatic op(input logic [31:0] c);
        int n;
        n = 0;
        wr(fbm_pkg::REG_CTRL, c);
        do begin
            rd(fbm_pkg::REG_STAT);
            n++;
        end while (d[0] !== 1'b0 && n < 300);
        comparisons++;
        if (d[0] !== 1'b0) begin
            failures++;
            $display("mismatch %0t operation never finished", $time);
            final_report;
        end else if (d[2] !== 1'b1) begin
            failures++;
            $display("mismatch %0t done flag not set", $time);
        end
    endtask
    task automatic fread(input logic [31:0] a, c, e);
        wr(fbm_pkg::REG_ADDR, a);
        op(c);
        rd(fbm_pkg::REG_RDAT);
        chk(e);
    endtask
    task automatic t_reset_vals;
        rd(fbm_pkg::REG_CTRL);
        chk(32'h0000_0028);
        rd(fbm_pkg::REG_STAT);
        chk(32'h0000_0002);
        rd(4'hF);
        chk(32'h0000_0000);
    endtask
    task automatic t_word_io;
        fread(32'h3, 32'h29, 32'h0000_C333);
        wr(fbm_pkg::REG_ADDR, 32'h5);
        wr(fbm_pkg::REG_DATA, 32'h1234);
        op(32'h2A);
        fread(32'h5, 32'h29, 32'h0000_1234);
    endtask
    task automatic t_byte_read;
        fread(32'hB, 32'h21, 32'h0000_0012);
        fread(32'hA, 32'h21, 32'h0000_0034);
    endtask
    task automatic t_hw_reset;
        op(32'h2C);
        chk(32'h0000_0006);
        fread(32'h3, 32'h29, 32'h0000_C333);
    endtask
    task automatic t_reset_mid_prog;
        wr(fbm_pkg::REG_ADDR, 32'h7);
        wr(fbm_pkg::REG_DATA, 32'h5A5A);
        op(32'h2A);
        op(32'h2C);
        chk(32'h0000_0006);
        d = {31'h0, rdy};
        chk(32'h0000_0001);
        fread(32'h7, 32'h29, 32'h0000_0000);
        op(32'h2A);
        fread(32'h7, 32'h29, 32'h0000_5A5A);
    endtask
    task automatic t_protect;
        wr(fbm_pkg::REG_ADDR, 32'h0);
        wr(fbm_pkg::REG_DATA, 32'h1111);
        op(32'h0A);
        fread(32'h0, 32'h29, 32'h0000_C030);
    endtask
    task automatic t_accel;
        wr(fbm_pkg::REG_ADDR, 32'hF);
        wr(fbm_pkg::REG_DATA, 32'hBEEF);
        op(32'h1A);
        fread(32'hF, 32'h29, 32'h0000_BEEF);
    endtask
    task automatic final_report;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        $display("mismatch %0t watchdog expired", $time);
        final_report;
    end
    initial begin
        repeat (10) @(posedge i_clock);
        i_rstn <= 1'b1;
        t_reset_vals;
        t_word_io;
        t_byte_read;
        t_hw_reset;
        t_reset_mid_prog;
        t_protect;
        t_accel;
        final_report;
    end
endmodule // tb_fbm_host

/* File: verilog/fbm_host.sv */
/*
 * Host controller that drives a dual-bank parallel flash through its pins.
 * Software sets address and data, then starts a read, a write cycle or a
 * hardware reset through the control register. The flash is asynchronous;
 * its ready/busy pin and data lines are synchronised before use.
 */
// Function
// - Reads hold chip and output enable low with write enable high.
// - Writes drive write and chip enable low with output enable high.
// - Host waits reset recovery time after release before reading.
`timescale 1ns/1ps

module fbm_host (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic [fbm_pkg::ADDR_W-1:0] o_flash_addr,
    output logic [fbm_pkg::DATA_W-1:0] o_dq_out,
    output logic [fbm_pkg::DATA_W-1:0] o_dq_oe,
    input wire logic [fbm_pkg::DATA_W-1:0] i_dq_in,
    output fbm_pkg::fbm_ctl_type o_ctl,
    input wire logic i_ready_busy_out
);

    // =========================================================
    // Input synchronisers
    // =========================================================
    logic [fbm_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q;
    logic ry_s1_q, ry_s2_q;

    always_ff @(posedge i_clock) begin
        dq_s1_q <= i_dq_in;
        dq_s2_q <= dq_s1_q;
        ry_s1_q <= i_ready_busy_out;
        ry_s2_q <= ry_s1_q;
    end

    // =========================================================
    // State
    // =========================================================
    fbm_pkg::fbm_state_type st_q, st_d;
    logic [fbm_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [22:0] addr_q, addr_d;
    logic [15:0] wdat_q, wdat_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [15:0] rdat_q, rdat_d;
    logic done_q, done_d;
    logic [31:0] rdata_q, rdata_d;
    fbm_pkg::fbm_ctl_type ctl_q, ctl_d;
    logic [fbm_pkg::ADDR_W-1:0] fa_q, fa_d;
    logic [15:0] dqo_q, dqo_d;
    logic [15:0] dqe_q, dqe_d;
    logic word_mode;

    assign word_mode = ctrl_q[fbm_pkg::CTRL_WORD];

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        ctrl_d = ctrl_q;
        rdat_d = rdat_q;
        done_d = done_q;
        rdata_d = 32'h0000_0000;
        ctl_d = ctl_q;
        fa_d = fa_q;
        dqo_d = dqo_q;
        dqe_d = 16'h0000;
        // Software register writes; commands accepted only when idle.
        if (i_wr) begin
            unique case (i_addr)
                fbm_pkg::REG_ADDR: addr_d = i_wdata[22:0];
                fbm_pkg::REG_DATA: wdat_d = i_wdata[15:0];
                fbm_pkg::REG_CTRL: ctrl_d = {26'h0, i_wdata[5:3], 3'h0};
                default: ;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                fbm_pkg::REG_ADDR: rdata_d = {9'h0, addr_q};
                fbm_pkg::REG_DATA: rdata_d = {16'h0, wdat_q};
                fbm_pkg::REG_CTRL: rdata_d = ctrl_q;
                fbm_pkg::REG_STAT: begin
                    rdata_d = {29'h0, done_q, ry_s2_q,
                        st_q != fbm_pkg::FBM_IDLE};
                    done_d = 1'b0;
                end
                fbm_pkg::REG_RDAT: rdata_d = {16'h0, rdat_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        ctl_d.word_sel = ctrl_q[fbm_pkg::CTRL_WORD];
        ctl_d.protect_accel = ctrl_q[fbm_pkg::CTRL_WP_HIGH];
        ctl_d.program_high_voltage = ctrl_q[fbm_pkg::CTRL_ACCEL];
        // Byte mode puts the lowest address bit on data line 15.
        fa_d = word_mode ? addr_q[20:0] : addr_q[21:1];
        unique case (st_q)
            fbm_pkg::FBM_IDLE: begin
                // Idle is standby: strobes high, data lines floated.
                ctl_d.ce_n = 1'b1;
                ctl_d.oe_n = 1'b1;
                ctl_d.we_n = 1'b1;
                ctl_d.reset_n = 1'b1;
                cnt_d = '0;
                if (i_wr && i_addr == fbm_pkg::REG_CTRL) begin
                    if (i_wdata[fbm_pkg::CTRL_GO_RESET]) begin
                        st_d = fbm_pkg::FBM_RST;
                    end else if (i_wdata[fbm_pkg::CTRL_GO_WRITE]) begin
                        st_d = fbm_pkg::FBM_WRITE;
                    end else if (i_wdata[fbm_pkg::CTRL_GO_READ]) begin
                        st_d = fbm_pkg::FBM_READ;
                    end
                end
            end
            fbm_pkg::FBM_READ: begin
                ctl_d.ce_n = 1'b0;
                ctl_d.oe_n = 1'b0;
                ctl_d.we_n = 1'b1;
                if (!word_mode) begin
                    dqe_d[15] = 1'b1;
                    dqo_d[15] = addr_q[0];
                end
                cnt_d = cnt_q + 1'b1;
                // Full access time plus two synchroniser stages.
                if (cnt_q == fbm_pkg::CNT_W'(fbm_pkg::ACC_CYCLES + 2)) begin
                    rdat_d = word_mode ? dq_s2_q
                        : {8'h00, dq_s2_q[7:0]};
                    done_d = 1'b1;
                    st_d = fbm_pkg::FBM_IDLE;
                end
            end
            fbm_pkg::FBM_WRITE: begin
                ctl_d.ce_n = 1'b0;
                ctl_d.oe_n = 1'b1;
                ctl_d.we_n = 1'b0;
                dqe_d = word_mode ? 16'hFFFF : 16'h80FF;
                dqo_d = word_mode ? wdat_q : {addr_q[0], 7'h00, wdat_q[7:0]};
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == fbm_pkg::CNT_W'(fbm_pkg::WR_CYCLES)) begin
                    ctl_d.we_n = 1'b1;
                    done_d = 1'b1;
                    st_d = fbm_pkg::FBM_IDLE;
                end
            end
            fbm_pkg::FBM_RST: begin
                ctl_d.reset_n = 1'b0;
                ctl_d.ce_n = 1'b1;
                ctl_d.oe_n = 1'b1;
                ctl_d.we_n = 1'b1;
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == fbm_pkg::CNT_W'(fbm_pkg::RP_CYCLES)) begin
                    ctl_d.reset_n = 1'b1;
                    cnt_d = '0;
                    st_d = fbm_pkg::FBM_RECOVER;
                end
            end
            fbm_pkg::FBM_RECOVER: begin
                // Wait recovery time and for ready/busy to go high.
                if (cnt_q != fbm_pkg::CNT_W'(fbm_pkg::RH_CYCLES)) begin
                    cnt_d = cnt_q + 1'b1;
                end else if (ry_s2_q) begin
                    done_d = 1'b1;
                    st_d = fbm_pkg::FBM_IDLE;
                end
            end
            default: st_d = fbm_pkg::FBM_IDLE;
        endcase
        // Set wins over a clear by a status read in the same cycle.
        if (i_rd && i_addr == fbm_pkg::REG_STAT && !(st_d == fbm_pkg::FBM_IDLE
                && st_q != fbm_pkg::FBM_IDLE)) begin
            done_d = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            st_q <= fbm_pkg::FBM_IDLE;
            cnt_q <= '0;
            addr_q <= 23'h000000;
            wdat_q <= 16'h0000;
            ctrl_q <= fbm_pkg::CTRL_RESET_VAL;
            rdat_q <= 16'h0000;
            done_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ctl_q <= 7'h7E;
            fa_q <= 21'h000000;
            dqo_q <= 16'h0000;
            dqe_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            ctrl_q <= ctrl_d;
            rdat_q <= rdat_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            ctl_q <= ctl_d;
            fa_q <= fa_d;
            dqo_q <= dqo_d;
            dqe_q <= dqe_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_ctl = ctl_q;
    assign o_flash_addr = fa_q;
    assign o_dq_out = dqo_q;
    assign o_dq_oe = dqe_q;

endmodule // fbm_host

/* File: verilog/fbm_pkg.sv */
/*
 * Package for the parallel flash host controller: command register map,
 * field positions, pin bundle types and timing counts.
 * Assumes a 125 MHz system clock and an asynchronous flash device
 * on the far side of the pins.
 */
package fbm_pkg;

    // =========================================================
    // Timing
    // =========================================================
    localparam int CLK_PERIOD_NS = 8;
    localparam int ADDRESS_ACCESS_TIME_NS = 110;
    localparam int CE_ACCESS_TIME_NS = 110;
    localparam int WRITE_PULSE_NS = 50;
    localparam int RESET_PULSE_MIN_WIDTH_NS = 500;
    localparam int RESET_RECOVERY_TIME_NS = 200;
    localparam int ACC_CYCLES =
        (CE_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYCLES =
        (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYCLES =
        (RESET_PULSE_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RH_CYCLES =
        (RESET_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // =========================================================
    // Software registers
    // =========================================================
    localparam logic [3:0] REG_ADDR = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h1;
    localparam logic [3:0] REG_CTRL = 4'h2;
    localparam logic [3:0] REG_STAT = 4'h3;
    localparam logic [3:0] REG_RDAT = 4'h4;

    // CTRL fields.
    localparam int CTRL_GO_READ = 0;
    localparam int CTRL_GO_WRITE = 1;
    localparam int CTRL_GO_RESET = 2;
    localparam int CTRL_WORD = 3;
    localparam int CTRL_ACCEL = 4;
    localparam int CTRL_WP_HIGH = 5;
    localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0028;

    // STAT fields.
    localparam int STAT_BUSY = 0;
    localparam int STAT_READY_PIN = 1;
    localparam int STAT_DONE = 2;

    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_n;
        logic word_sel;
        logic protect_accel;
        logic program_high_voltage;
    } fbm_ctl_type;

    typedef enum logic [2:0] {
        FBM_IDLE = 3'b000,
        FBM_READ = 3'b001,
        FBM_WRITE = 3'b010,
        FBM_RST = 3'b011,
        FBM_RECOVER = 3'b100
    } fbm_state_type;

endpackage
